// [logic/pir_regs.sv]
/*
 * Transceiver interrupt control/status, two saturating error counters
 * and the 100 Mb/s coding sublayer configuration register.
 * Assumes all event inputs come from logic on clk, and a simple
 * register port: one read or write request per cycle, answered next.
 */
`timescale 1ns/100ps
module pir_regs
    import pir_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire pir_req_s req,
    output logic [15:0] rdata,
    output logic rd_ack,
    // Transceiver side
    input wire pir_evt_s evt,
    input wire logic external_force_fast_link,
    input wire logic status_reg_read,
    // Results
    output pir_pcs_s pcs,
    output logic host_irq_status_transceiver_bit,
    output logic status_dup_irq_pending
);

    // Whole state of the block
    typedef struct packed {
        logic event_irq_enable;
        logic test_irq_force;
        logic irq_pending_flag;
        logic [5:0] mask;
        logic [7:0] fc_count;
        logic [7:0] rx_error_count;
        logic in_carrier;
        logic carrier_err;
        logic carrier_col;
        logic [15:0] pcs_cfg;
        logic force_eff;
        logic [15:0] rdata;
        logic ack;
    } pir_state_s;

    pir_state_s st_q;
    pir_state_s st_d;

    // Decodes and event terms
    logic rd_ctl, rd_stat, rd_fc, rd_re, rd_pcs;
    logic wr_ctl, wr_stat, wr_fc, wr_re, wr_pcs;
    logic carrier_end, re_count, fc_half, re_half;
    logic [5:0] evt_vec;
    logic evt_hit, test_hit;

    always_comb begin
        rd_ctl = req.rd && req.addr == PIR_OFS_CTL;
        rd_stat = req.rd && req.addr == PIR_OFS_STAT;
        rd_fc = req.rd && req.addr == PIR_OFS_FC;
        rd_re = req.rd && req.addr == PIR_OFS_RE;
        rd_pcs = req.rd && req.addr == PIR_OFS_PCS;
        wr_ctl = req.wr && req.addr == PIR_OFS_CTL;
        wr_stat = req.wr && req.addr == PIR_OFS_STAT;
        wr_fc = req.wr && req.addr == PIR_OFS_FC;
        wr_re = req.wr && req.addr == PIR_OFS_RE;
        wr_pcs = req.wr && req.addr == PIR_OFS_PCS;
    end

    // Next state
    always_comb begin
        st_d = st_q;

        // Control register: only two live bits, the rest dropped
        if (wr_ctl) begin
            st_d.event_irq_enable = req.wdata[PIR_B_EN];
            st_d.test_irq_force = req.wdata[PIR_B_TEST];
        end
        if (wr_stat) begin
            st_d.mask = req.wdata[PIR_B_PEND-1:PIR_B_MASK_LO];
        end

        // False carrier: write wins, then read clear, then count
        if (wr_fc) begin
            st_d.fc_count = req.wdata[7:0];
        end else begin
            if (rd_fc) begin
                st_d.fc_count = PIR_RST_CNT;
            end
            if (evt.false_carrier && st_q.fc_count != PIR_CNT_MAX) begin
                // Counts on top of a clear so the event is not lost, unless the old count sat at the ceiling
                st_d.fc_count = st_d.fc_count + 8'h01;
            end
        end

        // Carrier tracking: one error decision per carrier
        carrier_end = st_q.in_carrier && !evt.rx_carrier;
        re_count = carrier_end && st_q.carrier_err
            && !st_q.carrier_col;
        st_d.in_carrier = evt.rx_carrier;
        if (evt.rx_carrier) begin
            st_d.carrier_err = (st_q.in_carrier && st_q.carrier_err)
                || evt.rx_symbol_err;
            st_d.carrier_col = (st_q.in_carrier && st_q.carrier_col)
                || evt.rx_collision;
        end else begin
            st_d.carrier_err = 1'b0;
            st_d.carrier_col = 1'b0;
        end

        if (wr_re) begin
            st_d.rx_error_count = req.wdata[7:0];
        end else begin
            if (rd_re) begin
                st_d.rx_error_count = PIR_RST_CNT;
            end
            if (re_count && st_q.rx_error_count != PIR_CNT_MAX) begin
                st_d.rx_error_count = st_d.rx_error_count + 8'h01;
            end
        end

        // Half-full: bit 7 rising, once per transition
        fc_half = !st_q.fc_count[PIR_B_HALF]
            && st_d.fc_count[PIR_B_HALF];
        re_half = !st_q.rx_error_count[PIR_B_HALF]
            && st_d.rx_error_count[PIR_B_HALF];

        // Events against masks, order matches mask bits 14..9
        evt_vec = {evt.link_change, evt.jabber, evt.remote_fault,
            evt.autoneg_done, fc_half, re_half};
        evt_hit = st_q.event_irq_enable
            && |(evt_vec & ~st_q.mask);
        // Test path bypasses the enable on purpose
        test_hit = st_q.ack && st_q.test_irq_force;

        // Pending flag: the setting term beats a same-cycle read clear
        if (rd_stat || status_reg_read) begin
            st_d.irq_pending_flag = 1'b0;
        end
        if (evt_hit || test_hit) begin
            st_d.irq_pending_flag = 1'b1;
        end

        // Coding sublayer register, reserved bits held at zero
        if (wr_pcs) begin
            st_d.pcs_cfg = 16'h0000;
            st_d.pcs_cfg[PIR_B_BLK_BYP] = req.wdata[PIR_B_BLK_BYP];
            st_d.pcs_cfg[PIR_B_FREE_CLK] = req.wdata[PIR_B_FREE_CLK];
            st_d.pcs_cfg[PIR_B_TQ] = req.wdata[PIR_B_TQ];
            st_d.pcs_cfg[PIR_B_SD_FORCE] = req.wdata[PIR_B_SD_FORCE];
            st_d.pcs_cfg[PIR_B_SD_ALG] = req.wdata[PIR_B_SD_ALG];
            st_d.pcs_cfg[PIR_B_FORCE100] = req.wdata[PIR_B_FORCE100];
            st_d.pcs_cfg[PIR_B_NRZI] = req.wdata[PIR_B_NRZI];
        end
        st_d.force_eff = st_q.pcs_cfg[PIR_B_FORCE100]
            || external_force_fast_link;

        // Read data, captured from pre-update values
        st_d.ack = req.rd;
        st_d.rdata = 16'h0000;
        if (rd_ctl) begin
            st_d.rdata[PIR_B_EN] = st_q.event_irq_enable;
            st_d.rdata[PIR_B_TEST] = st_q.test_irq_force;
        end
        if (rd_stat) begin
            st_d.rdata[PIR_B_PEND] = st_q.irq_pending_flag;
            st_d.rdata[PIR_B_PEND-1:PIR_B_MASK_LO] = st_q.mask;
        end
        if (rd_fc) begin
            st_d.rdata[7:0] = st_q.fc_count;
        end
        if (rd_re) begin
            st_d.rdata[7:0] = st_q.rx_error_count;
        end
        if (rd_pcs) begin
            st_d.rdata = st_q.pcs_cfg;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.event_irq_enable <= PIR_RST_CTL[PIR_B_EN];
            st_q.test_irq_force <= PIR_RST_CTL[PIR_B_TEST];
            st_q.irq_pending_flag <= PIR_RST_STAT[PIR_B_PEND];
            st_q.mask <= PIR_RST_STAT[PIR_B_PEND-1:PIR_B_MASK_LO];
            st_q.fc_count <= PIR_RST_CNT;
            st_q.rx_error_count <= PIR_RST_CNT;
            st_q.pcs_cfg <= PIR_RST_PCS;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs, all from flops
    assign rdata = st_q.rdata;
    assign rd_ack = st_q.ack;
    assign host_irq_status_transceiver_bit = st_q.irq_pending_flag;
    assign status_dup_irq_pending = st_q.irq_pending_flag;
    assign pcs.block_code_bypass = st_q.pcs_cfg[PIR_B_BLK_BYP];
    assign pcs.free_running_rx_clock = st_q.pcs_cfg[PIR_B_FREE_CLK];
    assign pcs.true_quiet_enable = st_q.pcs_cfg[PIR_B_TQ];
    assign pcs.signal_detect_force = st_q.pcs_cfg[PIR_B_SD_FORCE];
    assign pcs.signal_detect_algorithm_select =
        st_q.pcs_cfg[PIR_B_SD_ALG];
    assign pcs.force_fast_link = st_q.force_eff;
    assign pcs.nrzi_bypass = st_q.pcs_cfg[PIR_B_NRZI];

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Completed read while test bit is set
    sequence s_test_read_done;
        rd_ack && st_q.test_irq_force;
    endsequence

    a_test_irq_read: assert property (
        s_test_read_done |=> host_irq_status_transceiver_bit)
        else $error("test interrupt not raised after read");

    a_event_irq_gated: assert property (
        $rose(host_irq_status_transceiver_bit) |->
        $past(evt_hit) || $past(test_hit))
        else $error("pending set without an allowed source");

    a_disabled_no_event: assert property (
        !st_q.event_irq_enable && !st_q.test_irq_force
        && !host_irq_status_transceiver_bit |=>
        !host_irq_status_transceiver_bit)
        else $error("pending set while all sources disabled");

    a_read_clears_pend: assert property (
        rd_stat && !evt_hit && !test_hit |=>
        rd_ack && rdata[PIR_B_PEND] == $past(st_q.irq_pending_flag)
        && !host_irq_status_transceiver_bit)
        else $error("status read did not return and clear pending");

    a_ctl_reserved_zero: assert property (
        rd_ctl ##1 rd_ack |-> rdata[15:2] == 14'h0000)
        else $error("control reserved bits not zero");

    a_fc_count_step: assert property (
        evt.false_carrier && !rd_fc && !wr_fc |=>
        st_q.fc_count == (($past(st_q.fc_count) == PIR_CNT_MAX) ?
        PIR_CNT_MAX : $past(st_q.fc_count) + 8'h01))
        else $error("false carrier count wrong");

    a_count_read_clear: assert property (
        rd_re && !re_count && !wr_re |=> st_q.rx_error_count == 8'h00
        ##0 rdata[7:0] == $past(st_q.rx_error_count))
        else $error("rx error counter not cleared by read");

    a_collision_blocks: assert property (
        carrier_end && st_q.carrier_col && !rd_re && !wr_re |=>
        $stable(st_q.rx_error_count))
        else $error("rx error counted despite collision");

    a_force_link_or: assert property (
        ##1 pcs.force_fast_link ==
        $past(st_q.pcs_cfg[PIR_B_FORCE100] || external_force_fast_link))
        else $error("fast link force not the OR");

    a_half_full_once: assert property (
        fc_half |=> !st_q.fc_count[PIR_B_HALF] == 1'b0 ##0 !fc_half)
        else $error("half-full event repeated");

    // A finished carrier with an error and no collision
    sequence s_carrier_close;
        carrier_end && st_q.carrier_err && !st_q.carrier_col;
    endsequence

    // Saturated counters hold while software leaves them alone
    a_fc_sat_hold: assert property (
        st_q.fc_count == PIR_CNT_MAX && !rd_fc && !wr_fc |=>
        st_q.fc_count == PIR_CNT_MAX)
        else $error("false carrier count left its ceiling");

    a_re_sat_hold: assert property (
        st_q.rx_error_count == PIR_CNT_MAX && !rd_re && !wr_re |=>
        st_q.rx_error_count == PIR_CNT_MAX)
        else $error("rx error count left its ceiling");

    // No count in mid-carrier, however many symbols are bad
    a_re_no_mid: assert property (
        st_q.in_carrier && evt.rx_carrier && !rd_re && !wr_re |=>
        $stable(st_q.rx_error_count))
        else $error("rx error counted before carrier ended");

    a_re_counts_err: assert property (
        s_carrier_close ##0 !rd_re && !wr_re
        && st_q.rx_error_count != PIR_CNT_MAX |=>
        st_q.rx_error_count == $past(st_q.rx_error_count) + 8'h01)
        else $error("rx error not counted for bad carrier");

    // Software write beats any same-cycle event or clear
    a_fc_write_wins: assert property (
        wr_fc |=> st_q.fc_count == $past(req.wdata[7:0]))
        else $error("false carrier write lost");

    a_re_write_wins: assert property (
        wr_re |=> st_q.rx_error_count == $past(req.wdata[7:0]))
        else $error("rx error write lost");

    a_fc_read_clear: assert property (
        rd_fc && !evt.false_carrier && !wr_fc |=>
        st_q.fc_count == 8'h00 ##0 rdata[7:0] == $past(st_q.fc_count))
        else $error("false carrier counter not cleared by read");

    // Reserved bits read as zero
    a_stat_reserved_zero: assert property (
        rd_stat |=> rdata[8:0] == 9'h000)
        else $error("status reserved bits not zero");

    a_pcs_reserved_zero: assert property (
        rd_pcs |=> (rdata & 16'he0db) == 16'h0000)
        else $error("coding config reserved bits not zero");

    // Read data only stands with its acknowledge
    a_rdata_idle_zero: assert property (
        !rd_ack |-> rdata == 16'h0000)
        else $error("read data not zero outside acknowledge");

    a_ack_follows_read: assert property (
        req.rd |=> rd_ack)
        else $error("read not acknowledged next cycle");

    // Control and mask writes land one cycle later
    a_ctl_write_bits: assert property (
        wr_ctl |=> st_q.event_irq_enable == $past(req.wdata[PIR_B_EN])
        && st_q.test_irq_force == $past(req.wdata[PIR_B_TEST]))
        else $error("control write not taken");

    a_mask_write: assert property (
        wr_stat |=> st_q.mask == $past(req.wdata[14:9]))
        else $error("mask write not taken");

    // All sources masked and pending low: pending stays low
    a_masked_quiet: assert property (
        !(|(evt_vec & ~st_q.mask)) && !test_hit
        && !host_irq_status_transceiver_bit |=>
        !host_irq_status_transceiver_bit)
        else $error("pending set by a masked event");

    a_ext_read_clears: assert property (
        status_reg_read && !evt_hit && !test_hit |=>
        !status_dup_irq_pending)
        else $error("status register read did not clear duplicate");

    // Unmasked half-full events reach the host bit
    a_fc_half_irq: assert property (
        fc_half && st_q.event_irq_enable && !st_q.mask[1] |=>
        host_irq_status_transceiver_bit)
        else $error("false carrier half-full not signalled");

    a_re_half_irq: assert property (
        re_half && st_q.event_irq_enable && !st_q.mask[0] |=>
        host_irq_status_transceiver_bit)
        else $error("rx error half-full not signalled");

    // Coding controls follow the written word
    a_pcs_write_hi: assert property (
        wr_pcs |=>
        pcs.block_code_bypass == $past(req.wdata[PIR_B_BLK_BYP])
        && pcs.free_running_rx_clock == $past(req.wdata[PIR_B_FREE_CLK])
        && pcs.true_quiet_enable == $past(req.wdata[PIR_B_TQ]))
        else $error("coding config upper bits not applied");

    a_pcs_write_lo: assert property (
        wr_pcs |=>
        pcs.signal_detect_force == $past(req.wdata[PIR_B_SD_FORCE])
        && pcs.signal_detect_algorithm_select ==
        $past(req.wdata[PIR_B_SD_ALG])
        && pcs.nrzi_bypass == $past(req.wdata[PIR_B_NRZI]))
        else $error("coding config lower bits not applied");

endmodule // pir_regs

// [pkg/pir_pkg.sv]
/*
 * Constants, field positions and carrier structs for the transceiver
 * interrupt, error counter and coding sublayer register block.
 * Assumes one device clock and a synchronous active high reset.
 */
package pir_pkg;

    // Register offsets
    localparam logic [7:0] PIR_OFS_CTL = 8'hc4;
    localparam logic [7:0] PIR_OFS_STAT = 8'hc8;
    localparam logic [7:0] PIR_OFS_FC = 8'hd0;
    localparam logic [7:0] PIR_OFS_RE = 8'hd4;
    localparam logic [7:0] PIR_OFS_PCS = 8'hd8;

    // Reset values
    localparam logic [15:0] PIR_RST_CTL = 16'h0000;
    localparam logic [15:0] PIR_RST_STAT = 16'h0000;
    localparam logic [7:0] PIR_RST_CNT = 8'h00;
    localparam logic [15:0] PIR_RST_PCS = 16'h0100;

    // Field positions
    localparam int PIR_B_TEST = 0;
    localparam int PIR_B_EN = 1;
    localparam int PIR_B_PEND = 15;
    localparam int PIR_B_MASK_LO = 9;
    localparam int PIR_B_HALF = 7;
    localparam int PIR_B_BLK_BYP = 12;
    localparam int PIR_B_FREE_CLK = 11;
    localparam int PIR_B_TQ = 10;
    localparam int PIR_B_SD_FORCE = 9;
    localparam int PIR_B_SD_ALG = 8;
    localparam int PIR_B_FORCE100 = 5;
    localparam int PIR_B_NRZI = 2;

    // Counter ceiling
    localparam logic [7:0] PIR_CNT_MAX = 8'hff;

    // Register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
    } pir_req_s;

    // Transceiver events and receive status, one clock domain
    typedef struct packed {
        logic link_change;
        logic jabber;
        logic remote_fault;
        logic autoneg_done;
        logic false_carrier;
        logic rx_carrier;
        logic rx_symbol_err;
        logic rx_collision;
    } pir_evt_s;

    // Coding sublayer controls toward the datapath
    typedef struct packed {
        logic block_code_bypass;
        logic free_running_rx_clock;
        logic true_quiet_enable;
        logic signal_detect_force;
        logic signal_detect_algorithm_select;
        logic force_fast_link;
        logic nrzi_bypass;
    } pir_pcs_s;

endpackage

// [verif/pir_regs_tb.sv]
/*
 * Self-checking bench for the transceiver interrupt, counter and coding
 * sublayer register block. Assumes pir_pkg is compiled first; the bench
 * drives every input itself, with no partner model.
 */
`timescale 1ns/100ps
module pir_regs_tb;
    import pir_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    pir_req_s req = '0;
    pir_evt_s evt = '0;
    logic ext_force = 1'b0;
    logic st_rd = 1'b0;
    logic [15:0] rdata;
    logic rd_ack;
    pir_pcs_s pcs;
    logic host_bit;
    logic dup_bit;
    int bad_count = 0;
    int samples_checked = 0;
    int n;
    logic [15:0] lfsr = 16'he8c5;
    logic [15:0] v;
    logic [15:0] m;

    pir_regs uut (
        .clk(clk), .srst(srst), .req(req), .rdata(rdata), .rd_ack(rd_ack),
        .evt(evt), .external_force_fast_link(ext_force),
        .status_reg_read(st_rd), .pcs(pcs),
        .host_irq_status_transceiver_bit(host_bit),
        .status_dup_irq_pending(dup_bit)
    );

    // 20 MHz device clock
    always #25 clk = ~clk;

    // Verdict and the only way out of the run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_word(string what, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_bit(string what, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask

    // Random source and expected-value helpers
    function automatic logic [15:0] lfsr_next(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [15:0] pcs_pins(logic [15:0] w, logic e);
        return {9'h000, w[12:8], w[5] | e, w[2]};
    endfunction

    // Idle cycle between requests so no strobe is set twice in a step
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk);
        #2 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        #2 req = '0;
    endtask

    task automatic rd_chk(string what, logic [7:0] a, logic [15:0] e);
        @(posedge clk);
        #2 req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge clk);
        #2 req = '0;
        chk_bit("rd_ack", 1'b1, rd_ack);
        chk_word(what, e, rdata);
    endtask

    // False carrier held k cycles counts k
    task automatic fc_run(int k);
        @(posedge clk);
        #2 evt.false_carrier = 1'b1;
        repeat (k) @(posedge clk);
        #2 evt.false_carrier = 1'b0;
    endtask

    // Error held four cycles must still count only once per carrier
    task automatic carrier(logic err, logic col);
        @(posedge clk);
        #2 evt = '{rx_carrier: 1'b1, rx_symbol_err: err,
                   rx_collision: col, default: 1'b0};
        repeat (4) @(posedge clk);
        #2 evt = '0;
        repeat (2) @(posedge clk);
    endtask

    // Source 0..3 are link, jabber, fault, autoneg; 4 and 5 half-full
    task automatic fire(int i);
        if (i < 4) begin
            @(posedge clk);
            #2 evt = pir_evt_s'(8'h80 >> i);
            @(posedge clk);
            #2 evt = '0;
        end else if (i == 4) begin
            wr(PIR_OFS_FC, 16'h007f);
            fc_run(1);
        end else begin
            wr(PIR_OFS_RE, 16'h007f);
            carrier(1'b1, 1'b0);
        end
    endtask

    // Pending is sticky, so a few cycles of settling is harmless
    task automatic irq_chk(logic e);
        repeat (4) @(posedge clk);
        #2 chk_bit("host_bit", e, host_bit);
        chk_bit("dup_bit", e, dup_bit);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        #2 srst = 1'b0;
        rd_chk("ctl", PIR_OFS_CTL, 16'h0000);
        rd_chk("stat", PIR_OFS_STAT, 16'h0000);
        rd_chk("fc", PIR_OFS_FC, 16'h0000);
        rd_chk("re", PIR_OFS_RE, 16'h0000);
        rd_chk("pcs", PIR_OFS_PCS, 16'h0100);
        rd_chk("unmapped", 8'hcc, 16'h0000);
        chk_bit("sd_alg", 1'b1, pcs.signal_detect_algorithm_select);
        // Test interrupt, with and without the event enable
        wr(PIR_OFS_CTL, 16'hffff);
        rd_chk("ctl", PIR_OFS_CTL, 16'h0003);
        irq_chk(1'b1);
        wr(PIR_OFS_CTL, 16'h0001);
        rd_chk("stat", PIR_OFS_STAT, 16'h8000);
        irq_chk(1'b1);
        wr(PIR_OFS_CTL, 16'h0000);
        rd_chk("stat", PIR_OFS_STAT, 16'h8000);
        irq_chk(1'b0);
        // Coding sublayer bits, corner words then random ones
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            ext_force = lfsr[7];
            v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : lfsr;
            wr(PIR_OFS_PCS, v);
            @(posedge clk);
            #2 chk_word("pcs_pins", pcs_pins(v, ext_force), {9'h000, pcs});
            rd_chk("pcs", PIR_OFS_PCS, v & 16'h1f24);
        end
        // False carrier counter: saturation, count, clear on read
        wr(PIR_OFS_FC, 16'hfffd);
        fc_run(5);
        rd_chk("fc", PIR_OFS_FC, 16'h00ff);
        lfsr = lfsr_next(lfsr);
        n = int'(lfsr[4:0]) + 1;
        fc_run(n);
        rd_chk("fc", PIR_OFS_FC, 16'(n));
        rd_chk("fc", PIR_OFS_FC, 16'h0000);
        // Receive error counter: once per carrier, collision, saturation
        carrier(1'b1, 1'b0);
        carrier(1'b0, 1'b0);
        carrier(1'b1, 1'b1);
        rd_chk("re", PIR_OFS_RE, 16'h0001);
        wr(PIR_OFS_RE, 16'h00ff);
        carrier(1'b1, 1'b0);
        rd_chk("re", PIR_OFS_RE, 16'h00ff);
        // Every source alone unmasked, then all masked
        wr(PIR_OFS_CTL, 16'h0002);
        for (int i = 0; i < 6; i++) begin
            m = 16'h7e00 & ~(16'h4000 >> i);
            wr(PIR_OFS_STAT, m);
            fire(i);
            irq_chk(1'b1);
            rd_chk("stat", PIR_OFS_STAT, m | 16'h8000);
            irq_chk(1'b0);
            wr(PIR_OFS_STAT, 16'hffff);
            fire(i);
            irq_chk(1'b0);
        end
        // Enable off suppresses; status register read clears
        wr(PIR_OFS_STAT, 16'h0000);
        wr(PIR_OFS_CTL, 16'h0000);
        fire(0);
        irq_chk(1'b0);
        wr(PIR_OFS_CTL, 16'h0002);
        fire(1);
        irq_chk(1'b1);
        @(posedge clk);
        #2 st_rd = 1'b1;
        @(posedge clk);
        #2 st_rd = 1'b0;
        irq_chk(1'b0);
        end_sim();
    end

    // Watchdog against a hung sequence
    initial begin
        #500000;
        bad_count++;
        end_sim();
    end
endmodule // pir_regs_tb
